// ---- verilog/sfcwsi_consts.vh ----
// Opcodes, status field positions and phase lengths of the flash command front-end
`ifndef SFCWSI_CONSTS_VH
`define SFCWSI_CONSTS_VH
`define SFCWSI_OP_WREN      8'h06
`define SFCWSI_OP_VWREN     8'h50
`define SFCWSI_OP_WRDI      8'h04
`define SFCWSI_OP_RDSR1     8'h05
`define SFCWSI_OP_RDSR2     8'h35
`define SFCWSI_OP_WRSR      8'h01
`define SFCWSI_OP_PP        8'h02
`define SFCWSI_OP_QPP       8'h32
`define SFCWSI_OP_SE        8'h20
`define SFCWSI_OP_BE32      8'h52
`define SFCWSI_OP_BE64      8'hd8
`define SFCWSI_OP_CE1       8'hc7
`define SFCWSI_OP_CE2       8'h60
`define SFCWSI_OP_READ      8'h03
`define SFCWSI_OP_FREAD     8'h0b
`define SFCWSI_OP_DOUT      8'h3b
`define SFCWSI_OP_QOUT      8'h6b
`define SFCWSI_OP_DIO       8'hbb
`define SFCWSI_OP_QIO       8'heb
`define SFCWSI_OP_WQIO      8'he7
`define SFCWSI_OP_OQIO      8'he3
`define SFCWSI_OP_WRAP      8'h77
`define SFCWSI_OP_RPD       8'hab
`define SFCWSI_OP_MFID      8'h90
`define SFCWSI_OP_MFID2     8'h92
`define SFCWSI_OP_MFID4     8'h94
`define SFCWSI_OP_SECER     8'h44
`define SFCWSI_OP_SECPR     8'h42
`define SFCWSI_OP_SECRD     8'h48
`define SFCWSI_STAT1_BUSY   0
`define SFCWSI_STAT1_WLATCH 1
`define SFCWSI_STAT2_QUAD   1
`define SFCWSI_ADDR_BITS    6'd24
`define SFCWSI_ADDR_M_BITS  6'd32
`define SFCWSI_DUMMY_FAST   4'd8
`define SFCWSI_DUMMY_QIO    4'd4
`define SFCWSI_DUMMY_WQIO   4'd2
`define SFCWSI_DUMMY_ID4    4'd4
`define SFCWSI_SEC_TOP      8'h00
`define SFCWSI_SEC_R1       8'h10
`define SFCWSI_SEC_R2       8'h20
`define SFCWSI_SEC_R3       8'h30
`define SFCWSI_WRAP_LSB     4
`define SFCWSI_WLATCH_RST   1'b0
`endif

// ---- verilog/sfcwsi_core.v ----
// Command front-end of a quad-lane serial flash: decode, lane mapping, write latch, status/ID
`timescale 1ns/1ps
`default_nettype none
`include "sfcwsi_consts.vh"

// Overview of operation
// - Two-lane output: lane 1 carries bits 7,5,3,1; lane 0 bits 6,4,2,0.
// - Two-lane address: lane 1 odd address/mode bits, lane 0 even bits.
// - Four-lane data: lane 3 bits 7 then 3, down to lane 0 bits 4, 0.
// - Four-lane address+mode takes eight clocks, lane 3 highest bit of each nibble.
// - Wrap command: seventh nibble lanes 0..2 carry wrap length bits 4..6.
// - Quad I/O fast read waits four dummy clocks before data.
// - Quad word read waits two dummy clocks; host keeps address bit 0 zero.
// - Power-down release returns part code byte repeatedly until select rises.
// - Dual ID command: address/mode on two lanes, then maker and part bytes.
// - Quad ID command: four lanes, four dummy clocks, maker/part bytes repeating.
// - Security registers: top byte zero, middle byte 10/20/30, low byte offset.
// - Write-enable opcode sets the write enable latch.
// - Single-byte commands: select low, eight rising-edge bits, select high.
// - Program and erase are refused unless the latch is set; status write also when volatile enable armed it.
// - Volatile enable leaves latch alone, arms only the next status write.
// - Write-disable opcode clears the write enable latch.
// - Latch clears at reset and when a program, erase or status write ends.
// - Status read shifts register 1 or 2 out MSB first on falling edges.
// - Status reads are executed even while a cycle is busy.
// - Status byte repeats while clocks run until select rises.
// - While busy every command but status read is ignored.
// - Write-class commands must end on a byte boundary or are discarded.
// - Select falling starts a command; first input byte, MSB first, is opcode.
module sfcwsi_core #(
  parameter [7:0] MAKER_CODE = 8'ha5,  // Arbitrary value
  parameter [7:0] PART_CODE  = 8'h3c   // Arbitrary value
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        cs_n_pin,
  input  wire        sclk_pin,
  input  wire [3:0]  io_in,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe_n,
  input  wire        busy_in,
  input  wire        cycle_done,
  input  wire [7:2]  status1_upper,
  input  wire [7:0]  status2_in,
  input  wire [7:0]  array_rd_data,
  output reg  [23:0] array_rd_addr,
  output reg         write_enable_latch,
  output reg         volatile_arm,
  output reg         cmd_go,
  output reg         cmd_volatile,
  output reg  [7:0]  cmd_opcode,
  output reg  [23:0] cmd_addr,
  output reg  [1:0]  sec_reg_sel,
  output reg  [7:0]  continuous_mode_bits,
  output reg  [2:0]  wrap_length_bits,
  output reg  [7:0]  data_in_byte,
  output reg         data_in_valid
);

  localparam [2:0] PH_IDLE  = 3'd0;
  localparam [2:0] PH_OP    = 3'd1;
  localparam [2:0] PH_ADDR  = 3'd2;
  localparam [2:0] PH_DUMMY = 3'd3;
  localparam [2:0] PH_OUT   = 3'd4;
  localparam [2:0] PH_IN    = 3'd5;
  localparam [2:0] PH_HOLD  = 3'd6;
  localparam [2:0] PH_IGN   = 3'd7;

  localparam [2:0] SRC_STAT1 = 3'd0;
  localparam [2:0] SRC_STAT2 = 3'd1;
  localparam [2:0] SRC_PART  = 3'd2;
  localparam [2:0] SRC_PAIR  = 3'd3;
  localparam [2:0] SRC_ARRAY = 3'd4;

  // Pin synchronisers
  reg        cs_s1_r, cs_s2_r, cs_s3_r;
  reg        ck_s1_r, ck_s2_r, ck_s3_r;
  reg  [3:0] io_s1_r, io_s2_r;

  reg  [2:0]  phase_r;
  reg  [7:0]  op_r;
  reg  [2:0]  op_cnt_r;
  reg  [2:0]  bits_lo_r;
  reg  [31:0] shin_r;
  reg  [5:0]  addr_cnt_r;
  reg  [5:0]  addr_need_r;
  reg  [2:0]  lanes_in_r;
  reg  [2:0]  lanes_out_r;
  reg  [3:0]  dummy_r;
  reg  [2:0]  after_addr_r;
  reg  [2:0]  src_r;
  reg         tog_r;
  reg  [7:0]  shout_r;
  reg  [2:0]  out_cnt_r;
  reg  [2:0]  in_cnt_r;

  wire cs_fall  = cs_s3_r & ~cs_s2_r;
  wire cs_rise  = ~cs_s3_r & cs_s2_r;
  wire ck_rise  = ck_s2_r & ~ck_s3_r;
  wire ck_fall  = ~ck_s2_r & ck_s3_r;
  wire quad_ok  = status2_in[`SFCWSI_STAT2_QUAD];

  function [31:0] shift_lanes;
    input [31:0] sh;
    input [2:0]  lanes;
    input [3:0]  io;
    begin
      case (lanes)
        3'd4:    shift_lanes = {sh[27:0], io};
        3'd2:    shift_lanes = {sh[29:0], io[1:0]};
        default: shift_lanes = {sh[30:0], io[0]};
      endcase
    end
  endfunction

  function [3:0] drive_lanes;
    input [7:0] b;
    input [2:0] lanes;
    begin
      case (lanes)
        3'd4:    drive_lanes = b[7:4];
        3'd2:    drive_lanes = {2'b00, b[7:6]};
        default: drive_lanes = {2'b00, b[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] enable_n;
    input [2:0] lanes;
    begin
      case (lanes)
        3'd4:    enable_n = 4'h0;
        3'd2:    enable_n = 4'hc;
        default: enable_n = 4'hd;
      endcase
    end
  endfunction

  function is_write_class;
    input [7:0] op;
    begin
      case (op)
        `SFCWSI_OP_WRSR, `SFCWSI_OP_PP, `SFCWSI_OP_QPP, `SFCWSI_OP_SE,
        `SFCWSI_OP_BE32, `SFCWSI_OP_BE64, `SFCWSI_OP_CE1, `SFCWSI_OP_CE2,
        `SFCWSI_OP_SECER, `SFCWSI_OP_SECPR: is_write_class = 1'b1;
        default: is_write_class = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] next_byte;
  always @* begin
    case (src_r)
      SRC_STAT1: next_byte = {status1_upper, write_enable_latch, busy_in};
      SRC_STAT2: next_byte = status2_in;
      SRC_PART:  next_byte = PART_CODE;
      SRC_PAIR:  next_byte = tog_r ? PART_CODE : MAKER_CODE;
      default:   next_byte = array_rd_data;
    endcase
  end

  // Security register window decode
  wire       sec_top_ok = (shin_r[23:16] == `SFCWSI_SEC_TOP);
  wire [1:0] sec_decode = !sec_top_ok ? 2'd0 :
                          (shin_r[15:8] == `SFCWSI_SEC_R1) ? 2'd1 :
                          (shin_r[15:8] == `SFCWSI_SEC_R2) ? 2'd2 :
                          (shin_r[15:8] == `SFCWSI_SEC_R3) ? 2'd3 : 2'd0;
  wire       op_is_sec  = (op_r == `SFCWSI_OP_SECER) || (op_r == `SFCWSI_OP_SECPR) ||
                          (op_r == `SFCWSI_OP_SECRD);

  // Frame end checks
  wire frame_whole = (phase_r != PH_OP) && (bits_lo_r == 3'd0);
  wire wr_phase_ok = (phase_r == PH_IN) || (phase_r == PH_HOLD);
  wire wr_enabled  = write_enable_latch ||
                     (volatile_arm && (op_r == `SFCWSI_OP_WRSR));
  wire wr_sec_ok   = !op_is_sec || (sec_reg_sel != 2'd0);
  wire wr_accept   = is_write_class(op_r) && wr_phase_ok && frame_whole &&
                     wr_enabled && wr_sec_ok;
  wire single_done = (phase_r == PH_HOLD) && frame_whole && (addr_need_r == 6'd0);

  wire [7:0] op_next  = {op_r[6:0], io_s2_r[0]};
  wire [31:0] sh_next = shift_lanes(shin_r, lanes_in_r, io_s2_r);
  wire [5:0] addr_cnt_next = addr_cnt_r + {3'b000, lanes_in_r};
  wire [2:0] bits_next = bits_lo_r + lanes_in_r;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      cs_s1_r <= cs_n_pin;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      ck_s1_r <= sclk_pin;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_r              <= PH_IDLE;
      op_r                 <= 8'h00;
      op_cnt_r             <= 3'd0;
      bits_lo_r            <= 3'd0;
      shin_r               <= 32'h0000_0000;
      addr_cnt_r           <= 6'd0;
      addr_need_r          <= 6'd0;
      lanes_in_r           <= 3'd1;
      lanes_out_r          <= 3'd1;
      dummy_r              <= 4'd0;
      after_addr_r         <= PH_HOLD;
      src_r                <= SRC_STAT1;
      tog_r                <= 1'b0;
      shout_r              <= 8'h00;
      out_cnt_r            <= 3'd0;
      in_cnt_r             <= 3'd0;
      io_out               <= 4'h0;
      io_oe_n              <= 4'hf;
      array_rd_addr        <= 24'h00_0000;
      write_enable_latch   <= `SFCWSI_WLATCH_RST;
      volatile_arm         <= 1'b0;
      cmd_go               <= 1'b0;
      cmd_volatile         <= 1'b0;
      cmd_opcode           <= 8'h00;
      cmd_addr             <= 24'h00_0000;
      sec_reg_sel          <= 2'd0;
      continuous_mode_bits <= 8'h00;
      wrap_length_bits     <= 3'd0;
      data_in_byte         <= 8'h00;
      data_in_valid        <= 1'b0;
    end else begin
      cmd_go        <= 1'b0;
      data_in_valid <= 1'b0;
      if (cycle_done) begin
        write_enable_latch <= 1'b0;
      end
      if (cs_rise) begin
        // Frame end executes single-byte and write-class commands
        phase_r <= PH_IDLE;
        io_oe_n <= 4'hf;
        if (phase_r != PH_IGN && phase_r != PH_IDLE && phase_r != PH_OP) begin
          volatile_arm <= 1'b0;
          if (single_done && op_r == `SFCWSI_OP_WREN) begin
            write_enable_latch <= 1'b1;
          end
          if (single_done && op_r == `SFCWSI_OP_WRDI && !cycle_done) begin
            write_enable_latch <= 1'b0;
          end
          if (single_done && op_r == `SFCWSI_OP_VWREN) begin
            volatile_arm <= 1'b1;
          end
          if (wr_accept) begin
            cmd_go       <= 1'b1;
            cmd_opcode   <= op_r;
            cmd_volatile <= !write_enable_latch;
          end
        end
      end else if (cs_fall) begin
        phase_r   <= PH_OP;
        op_cnt_r  <= 3'd0;
        bits_lo_r <= 3'd0;
        io_oe_n   <= 4'hf;
      end else if (!cs_s2_r && ck_rise) begin
        case (phase_r)
          PH_OP: begin
            op_r      <= op_next;
            op_cnt_r  <= op_cnt_r + 3'd1;
            bits_lo_r <= bits_lo_r + 3'd1;
            if (op_cnt_r == 3'd7) begin
              addr_cnt_r   <= 6'd0;
              addr_need_r  <= `SFCWSI_ADDR_BITS;
              lanes_in_r   <= 3'd1;
              lanes_out_r  <= 3'd1;
              dummy_r      <= 4'd0;
              after_addr_r <= PH_OUT;
              src_r        <= SRC_ARRAY;
              tog_r        <= 1'b0;
              out_cnt_r    <= 3'd0;
              in_cnt_r     <= 3'd0;
              phase_r      <= PH_ADDR;
              if (busy_in && op_next != `SFCWSI_OP_RDSR1 &&
                  op_next != `SFCWSI_OP_RDSR2) begin
                phase_r <= PH_IGN;
              end else begin
                case (op_next)
                  `SFCWSI_OP_RDSR1, `SFCWSI_OP_RDSR2: begin
                    src_r   <= (op_next == `SFCWSI_OP_RDSR1) ? SRC_STAT1 : SRC_STAT2;
                    phase_r <= PH_OUT;
                  end
                  `SFCWSI_OP_WREN, `SFCWSI_OP_WRDI, `SFCWSI_OP_VWREN,
                  `SFCWSI_OP_CE1, `SFCWSI_OP_CE2: begin
                    addr_need_r <= 6'd0;
                    phase_r     <= PH_HOLD;
                  end
                  `SFCWSI_OP_WRSR: begin
                    addr_need_r <= 6'd0;
                    phase_r     <= PH_IN;
                  end
                  `SFCWSI_OP_PP, `SFCWSI_OP_SECPR: after_addr_r <= PH_IN;
                  `SFCWSI_OP_QPP: begin
                    after_addr_r <= PH_IN;
                    if (!quad_ok) phase_r <= PH_IGN;
                  end
                  `SFCWSI_OP_SE, `SFCWSI_OP_BE32, `SFCWSI_OP_BE64,
                  `SFCWSI_OP_SECER: after_addr_r <= PH_HOLD;
                  `SFCWSI_OP_READ: dummy_r <= 4'd0;
                  `SFCWSI_OP_FREAD, `SFCWSI_OP_SECRD: dummy_r <= `SFCWSI_DUMMY_FAST;
                  `SFCWSI_OP_DOUT: begin
                    dummy_r     <= `SFCWSI_DUMMY_FAST;
                    lanes_out_r <= 3'd2;
                  end
                  `SFCWSI_OP_QOUT: begin
                    dummy_r     <= `SFCWSI_DUMMY_FAST;
                    lanes_out_r <= 3'd4;
                    if (!quad_ok) phase_r <= PH_IGN;
                  end
                  `SFCWSI_OP_DIO, `SFCWSI_OP_MFID2: begin
                    addr_need_r <= `SFCWSI_ADDR_M_BITS;
                    lanes_in_r  <= 3'd2;
                    lanes_out_r <= 3'd2;
                    if (op_next == `SFCWSI_OP_MFID2) src_r <= SRC_PAIR;
                  end
                  `SFCWSI_OP_QIO, `SFCWSI_OP_WQIO, `SFCWSI_OP_OQIO,
                  `SFCWSI_OP_MFID4, `SFCWSI_OP_WRAP: begin
                    addr_need_r <= `SFCWSI_ADDR_M_BITS;
                    lanes_in_r  <= 3'd4;
                    lanes_out_r <= 3'd4;
                    case (op_next)
                      `SFCWSI_OP_QIO:   dummy_r <= `SFCWSI_DUMMY_QIO;
                      `SFCWSI_OP_WQIO:  dummy_r <= `SFCWSI_DUMMY_WQIO;
                      `SFCWSI_OP_MFID4: dummy_r <= `SFCWSI_DUMMY_ID4;
                      default:          dummy_r <= 4'd0;
                    endcase
                    if (op_next == `SFCWSI_OP_MFID4) src_r <= SRC_PAIR;
                    if (op_next == `SFCWSI_OP_WRAP) after_addr_r <= PH_HOLD;
                    if (!quad_ok) phase_r <= PH_IGN;
                  end
                  `SFCWSI_OP_RPD: src_r <= SRC_PART;
                  `SFCWSI_OP_MFID: src_r <= SRC_PAIR;
                  default: phase_r <= PH_IGN;
                endcase
              end
            end
          end
          PH_ADDR: begin
            shin_r     <= sh_next;
            addr_cnt_r <= addr_cnt_next;
            bits_lo_r  <= bits_next;
            if (addr_cnt_next == addr_need_r) begin
              if (addr_need_r == `SFCWSI_ADDR_M_BITS) begin
                cmd_addr             <= sh_next[31:8];
                array_rd_addr        <= sh_next[31:8];
                continuous_mode_bits <= sh_next[7:0];
                sec_reg_sel          <= 2'd0;
              end else begin
                cmd_addr      <= sh_next[23:0];
                array_rd_addr <= sh_next[23:0];
              end
              if (op_r == `SFCWSI_OP_QPP) lanes_in_r <= 3'd4;
              if (op_r == `SFCWSI_OP_WRAP) begin
                wrap_length_bits <= sh_next[`SFCWSI_WRAP_LSB+2:`SFCWSI_WRAP_LSB];
              end
              if (op_r == `SFCWSI_OP_MFID) tog_r <= sh_next[0];
              if (dummy_r != 4'd0) phase_r <= PH_DUMMY;
              else phase_r <= after_addr_r;
            end
            if (addr_cnt_r == 6'd16 && op_is_sec) begin
              sec_reg_sel <= 2'd0;
            end
          end
          PH_DUMMY: begin
            dummy_r <= dummy_r - 4'd1;
            if (dummy_r == 4'd1) phase_r <= PH_OUT;
          end
          PH_IN: begin
            shin_r    <= sh_next;
            bits_lo_r <= bits_next;
            if (bits_next == 3'd0) begin
              data_in_byte  <= sh_next[7:0];
              data_in_valid <= 1'b1;
            end
          end
          PH_HOLD: bits_lo_r <= bits_lo_r + 3'd1;
          default: bits_lo_r <= bits_lo_r;
        endcase
      end else if (!cs_s2_r && ck_fall && phase_r == PH_OUT) begin
        // Output lanes change on the falling edge
        io_oe_n <= enable_n(lanes_out_r);
        if (out_cnt_r == 3'd0) begin
          io_out    <= drive_lanes(next_byte, lanes_out_r);
          shout_r   <= next_byte << lanes_out_r;
          out_cnt_r <= 3'd0 - lanes_out_r;
          tog_r     <= ~tog_r;
          if (src_r == SRC_ARRAY) array_rd_addr <= array_rd_addr + 24'h00_0001;
        end else begin
          io_out    <= drive_lanes(shout_r, lanes_out_r);
          shout_r   <= shout_r << lanes_out_r;
          out_cnt_r <= out_cnt_r - lanes_out_r;
        end
      end else if (op_is_sec && phase_r == PH_ADDR && addr_cnt_r == addr_need_r) begin
        sec_reg_sel <= sec_decode;
      end else if (op_is_sec && phase_r != PH_ADDR && phase_r != PH_IDLE &&
                   sec_reg_sel == 2'd0 && sec_decode != 2'd0 && addr_cnt_r == 6'd24) begin
        sec_reg_sel <= sec_decode;
        if (op_r == `SFCWSI_OP_SECRD && sec_decode == 2'd0) phase_r <= PH_IGN;
      end
    end
  end

endmodule // sfcwsi_core
`default_nettype wire

// ---- sim/sfcwsi_props.sv ----
// Concurrent checks on the flash command front-end ports
`timescale 1ns/1ps
`default_nettype none
module sfcwsi_props (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        cs_n_pin,
  input wire logic [3:0]  io_oe_n,
  input wire logic        busy_in,
  input wire logic        cycle_done,
  input wire logic        write_enable_latch,
  input wire logic        volatile_arm,
  input wire logic        cmd_go,
  input wire logic        cmd_volatile,
  input wire logic [7:0]  cmd_opcode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence cs_idle6;
    cs_n_pin [*6];
  endsequence
  sequence busy_run8;
    busy_in [*8];
  endsequence
  AST_RST_QUIET: assert property (disable iff (1'b0)
    reset |-> io_oe_n == 4'hf && !write_enable_latch && !cmd_go)
    else $error("outputs active in reset");
  AST_CS_RELEASE: assert property (cs_idle6 |-> io_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  AST_OE_LEGAL: assert property (io_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("illegal lane enable pattern");
  AST_OE_IN_FRAME: assert property ($fell(io_oe_n[1]) |-> !cs_n_pin)
    else $error("lane driven outside a frame");
  AST_GO_PULSE: assert property (cmd_go |-> cs_n_pin ##1 !cmd_go)
    else $error("accept pulse not single or inside frame");
  AST_GO_LATCH: assert property (cmd_go && !cmd_volatile |-> $past(write_enable_latch))
    else $error("write accepted without latch");
  AST_GO_VOL: assert property (
    cmd_go && cmd_volatile |-> cmd_opcode == 8'h01 && !write_enable_latch)
    else $error("volatile accept not a status write");
  AST_ARM_KEEP: assert property (
    $rose(volatile_arm) |-> write_enable_latch == $past(write_enable_latch))
    else $error("volatile enable moved the latch");
  AST_DONE_CLR: assert property (cycle_done |=> !write_enable_latch)
    else $error("latch not cleared at cycle end");
  AST_LATCH_SET: assert property (
    $rose(write_enable_latch) |-> cs_n_pin && !busy_in)
    else $error("latch set mid frame or while busy");
  AST_BUSY_MUTE: assert property (busy_run8 |-> !cmd_go && !$rose(write_enable_latch))
    else $error("command acted on while busy");
endmodule // sfcwsi_props
bind sfcwsi_core sfcwsi_props sfcwsi_props_inst (.clk_sys(clk_sys), .reset(reset),
  .cs_n_pin(cs_n_pin), .io_oe_n(io_oe_n), .busy_in(busy_in), .cycle_done(cycle_done),
  .write_enable_latch(write_enable_latch), .volatile_arm(volatile_arm), .cmd_go(cmd_go),
  .cmd_volatile(cmd_volatile), .cmd_opcode(cmd_opcode));
`default_nettype wire

// ---- sim/sfcwsi_host.sv ----
// Behavioural host controller driving select, serial clock and lanes
`timescale 1ns/1ps
`default_nettype none
module sfcwsi_host (
  input  wire logic       clk_sys,
  output var  logic       cs_n_pin,
  output var  logic       sclk_pin,
  output wire logic [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n
);
  logic [3:0] drv_v;
  logic [3:0] drv_en;
  logic [3:0] idle_pat;
  // Released lanes carry a moving pattern
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv_en & drv_v) | (io_oe_n & ~drv_en & idle_pat);
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    drv_v = 4'h0;
    drv_en = 4'h0;
    idle_pat = 4'h5;
  end
  always @(negedge clk_sys) begin
    idle_pat <= ~idle_pat;
  end
  task automatic sel(input logic on);
    drv_en = 4'h0;
    #200 cs_n_pin = ~on;
    #(on ? 200 : 400);
  endtask
  // Clock stays low between frames; data set in low phase, read at end of high
  task automatic clocks(input logic [31:0] v, input int n, li, lo, output logic [31:0] rx);
    logic [3:0] smp;
    rx = 32'h0;
    for (int i = 0; i < n; i++) begin
      drv_en = 4'hf >> (4 - li);
      drv_v = v[31:28] >> (4 - li);
      v = v << li;
      #200 sclk_pin = 1'b1;
      #190 smp = (lo == 1) ? {3'h0, io_in[1]} : (lo == 2) ? {2'h0, io_in[1:0]} : io_in;
      if (lo > 0) rx = (rx << lo) | smp;
      #10 sclk_pin = 1'b0;
    end
  endtask
endmodule // sfcwsi_host
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the flash command front-end
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] MAKER = 8'ha5; // Arbitrary value
  localparam logic [7:0] PART  = 8'h3c; // Arbitrary value
  logic        clk_sys, reset, busy_in, cycle_done, cs_n_pin, sclk_pin;
  logic [3:0]  io_in, io_out, io_oe_n, oe_seen;
  logic [7:2]  status1_upper;
  logic [7:0]  status2_in, array_rd_data, cmd_opcode, continuous_mode_bits, mode, exp;
  logic [7:0]  data_in_byte, din_last;
  logic        data_in_valid;
  logic [23:0] array_rd_addr, cmd_addr, a;
  logic [31:0] rx, word;
  logic [1:0]  sec_reg_sel;
  logic [2:0]  wrap_length_bits;
  logic        write_enable_latch, volatile_arm, cmd_go, cmd_volatile, go_vol;
  int          fails, comparisons, gos, g;
  logic [7:0]  qop [3] = '{8'heb, 8'he7, 8'he3};
  int          qd [3] = '{4, 2, 0};
  logic [23:0] qm [3] = '{24'h0, 24'h1, 24'hf};
  function automatic logic [7:0] mem(input logic [23:0] ad);
    mem = ad[7:0] ^ ad[15:8] ^ 8'h5a;
  endfunction
  assign array_rd_data = mem(array_rd_addr);
  sfcwsi_core #(.MAKER_CODE(MAKER), .PART_CODE(PART)) sfcwsi_core_inst (.clk_sys(clk_sys),
    .reset(reset), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .busy_in(busy_in), .cycle_done(cycle_done), .status1_upper(status1_upper),
    .status2_in(status2_in), .array_rd_data(array_rd_data), .array_rd_addr(array_rd_addr),
    .write_enable_latch(write_enable_latch), .volatile_arm(volatile_arm), .cmd_go(cmd_go),
    .cmd_volatile(cmd_volatile), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
    .sec_reg_sel(sec_reg_sel), .continuous_mode_bits(continuous_mode_bits),
    .wrap_length_bits(wrap_length_bits), .data_in_byte(data_in_byte),
    .data_in_valid(data_in_valid));
  sfcwsi_host sfcwsi_host_inst (.clk_sys(clk_sys), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (cmd_go === 1'b1) begin
      gos <= gos + 1;
      go_vol <= cmd_volatile;
    end
    if (data_in_valid === 1'b1) din_last <= data_in_byte;
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] expv);
    comparisons++;
    if (seen !== expv) begin
      fails++;
      $display("Error %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] v, input int n, li, d, o, lo);
    logic [31:0] dmy;
    sfcwsi_host_inst.sel(1'b1);
    sfcwsi_host_inst.clocks({op, 24'h0}, 8, 1, 0, dmy);
    if (n > 0) sfcwsi_host_inst.clocks(v, n, li, 0, dmy);
    if (d > 0) sfcwsi_host_inst.clocks(32'h0, d, 0, 0, dmy);
    rx = 32'h0;
    if (o > 0) sfcwsi_host_inst.clocks(32'h0, o, 0, lo, rx);
    oe_seen = io_oe_n;
    sfcwsi_host_inst.sel(1'b0);
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
  initial begin
    reset = 1'b1; busy_in = 1'b0; cycle_done = 1'b0; status1_upper = 6'h00; status2_in = 8'h00;
    gos = 0; go_vol = 1'b0;
    void'($urandom(8166));
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      status1_upper = $urandom;
      status2_in = $urandom;
      busy_in = k[0];
      frame(k < 2 ? 8'h05 : 8'h35, 32'h0, 0, 0, 0, 16, 1);
      exp = (k < 2) ? {status1_upper, 1'b0, busy_in} : status2_in;
      check("status", rx, {16'h0, exp, exp});
    end
    busy_in = 1'b0;
    frame(8'h06, 32'h0, 0, 0, 0, 0, 0);
    check("latch set", write_enable_latch, 1'b1);
    frame(8'h50, 32'h0, 0, 0, 0, 0, 0);
    check("arm latch", {volatile_arm, write_enable_latch}, 2'b11);
    frame(8'h04, 32'h0, 0, 0, 0, 0, 0);
    check("latch clear", write_enable_latch, 1'b0);
    g = gos;
    frame(8'h50, 32'h0, 0, 0, 0, 0, 0);
    frame(8'h01, {$urandom} << 24, 8, 1, 0, 0, 0);
    check("volatile write", {gos - g, go_vol, write_enable_latch}, {g - g + 1, 2'b10});
    frame(8'h20, {$urandom} << 8, 24, 1, 0, 0, 0);
    check("erase refused", gos - g, 1);
    a = $urandom;
    exp = $urandom;
    frame(8'h06, 32'h0, 0, 0, 0, 0, 0);
    frame(8'h02, {a, exp}, 32, 1, 0, 0, 0);
    check("program", {gos - g, cmd_opcode, cmd_addr}, {32'd2, 8'h02, a});
    check("data byte", din_last, exp);
    @(negedge clk_sys) cycle_done = 1'b1;
    @(negedge clk_sys) cycle_done = 1'b0;
    check("done clear", write_enable_latch, 1'b0);
    frame(8'h06, 32'h0, 0, 0, 0, 0, 0);
    frame(8'h02, $urandom, 29, 1, 0, 0, 0);
    check("partial byte", gos - g, 2);
    frame(8'h04, 32'h0, 0, 0, 0, 0, 0);
    busy_in = 1'b1;
    frame(8'h06, 32'h0, 0, 0, 0, 0, 0);
    check("busy ignore", write_enable_latch, 1'b0);
    busy_in = 1'b0;
    frame(8'h11, 32'h0, 0, 0, 0, 8, 1);
    check("unknown op", oe_seen, 4'hf);
    frame(8'hab, $urandom, 24, 1, 0, 16, 1);
    check("part code", rx, {16'h0, PART, PART});
    for (int r = 1; r < 4; r++) begin
      a = $urandom;
      a[23:8] = {8'h00, 4'(r), 4'h0};
      frame(8'h48, {a, 8'h00}, 24, 1, 8, 0, 0);
      check("security sel", sec_reg_sel, r);
    end
    status2_in = 8'h02;
    mode = $urandom & 8'hcf;
    frame(8'h92, {24'h0, mode}, 16, 2, 0, 8, 2);
    check("dual id", {rx[15:0], continuous_mode_bits}, {MAKER, PART, mode});
    a = $urandom;
    frame(8'hbb, {a, mode}, 16, 2, 0, 8, 2);
    check("dual read", rx, {16'h0, mem(a), mem(a + 24'h1)});
    frame(8'h94, {24'h0, mode}, 8, 4, 4, 8, 4);
    check("quad id", rx, {MAKER, PART, MAKER, PART});
    word = $urandom;
    frame(8'h77, word, 8, 4, 0, 0, 0);
    check("wrap", wrap_length_bits, word[6:4]);
    for (int k = 0; k < 3; k++) begin
      a = $urandom & ~qm[k];
      frame(qop[k], {a, mode}, 8, 4, qd[k], 4, 4);
      check("quad read", rx, {16'h0, mem(a), mem(a + 24'h1)});
    end
    end_sim();
  end
endmodule // tb
`default_nettype wire
